// *** core/wdr_core.sv ***
// Purpose: supervision timer with timed-sequence protection and a reset-cause flag register
// Assumes: reset_n is the power-on reset; system resets caused elsewhere do not reset this block
// Notes:   one wait state on every Avalon access; reserved prescale codes act as code 9
`timescale 1ns/10ps

module wdr_core
  import wdr_pkg::*;
#(
  parameter int unsigned OSC_DIV    = OSC_DIV_CYCLES,
  parameter int unsigned BASE_TICKS = PRE_BASE_TICKS
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              restart_cmd,
  input  wire logic              irq_vector_ack,
  input  wire logic              always_on_option,
  input  wire logic              pin_reset_evt,
  input  wire logic              supply_drop_evt,
  input  wire logic              scan_reset_evt,
  input  wire logic              usb_reset_evt,
  output logic                   timeout_irq,
  output logic                   timeout_sys_reset
);

  localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // terminal count of the selected period, in oscillator ticks
  function automatic logic [CNT_W-1:0] tick_last(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PRE_MAX_CODE) ? PRE_MAX_CODE : code;
    return (CNT_W'(BASE_TICKS) << c) - CNT_W'(1);
  endfunction : tick_last

  // input synchronisers: a change counts once stages two and three agree
  logic [SRC_N-1:0] sync1_r;
  logic [SRC_N-1:0] sync2_r;
  logic [SRC_N-1:0] sync3_r;
  logic [SRC_N-1:0] filt_r;
  wire  [SRC_N-1:0] ext_in   = {always_on_option, usb_reset_evt, scan_reset_evt, supply_drop_evt, pin_reset_evt};
  wire  [SRC_N-1:0] agree    = ~(sync2_r ^ sync3_r);
  wire  [SRC_N-1:0] filt_nxt = (agree & sync2_r) | (~agree & filt_r);
  wire  [SRC_N-1:0] src_rise = filt_nxt & ~filt_r;
  wire              aon      = filt_r[SRC_AON];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r  <= '0;
    end else begin
      sync1_r <= ext_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
    end
  end

  // registers
  wdr_ctrl_t        ctrl_r;
  wdr_ctrl_t        ctrl_nxt;
  wdr_flags_t       flags_r;
  wdr_flags_t       flags_nxt;
  wdr_win_t         win_r;
  wdr_win_t         win_nxt;
  logic [2:0]       ce_cnt_r;
  logic [2:0]       ce_cnt_nxt;
  logic [DIV_W-1:0] div_r;
  logic             osc_tick_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             wait_r;
  logic [DATA_W-1:0] rdata_r;
  logic             irq_r;
  logic             sysrst_r;

  // avalon slave: the first cycle of a request is always stalled
  wire        req       = avs_read | avs_write;
  wire        take      = req & ~wait_r;
  wire        do_wr     = avs_write & take & avs_byteenable[0];
  wire        sel_flags = (avs_address == OFS_FLAGS);
  wire        sel_ctrl  = (avs_address == OFS_CTRL);
  wire        wr_flags  = do_wr & sel_flags;
  wire        wr_ctrl   = do_wr & sel_ctrl;
  wire wdr_flags_t wr_f = wdr_flags_t'(avs_writedata[7:0]);
  wire wdr_ctrl_t  wr_c = wdr_ctrl_t'(avs_writedata[7:0]);

  // effective mode, with the fuse and the timeout flag overriding stored bits
  wire        wde_eff   = ctrl_r.rst_en | flags_r.timeout | aon;
  wire        timeout_irq_enable_eff  = ctrl_r.irq_en & ~aon;
  wire        running   = wde_eff | timeout_irq_enable_eff;
  wire        intr_mode = timeout_irq_enable_eff & ~wde_eff;
  wire        comb_mode = timeout_irq_enable_eff & wde_eff;
  wire        rst_mode  = wde_eff & ~timeout_irq_enable_eff;
  wire [3:0]  pre_code  = {ctrl_r.pre_hi, ctrl_r.pre_lo};
  wire [CNT_W-1:0] last = tick_last(pre_code);

  wire        expire    = osc_tick_r & running & (cnt_r == last);
  wire        fire_irq  = expire & (intr_mode | (comb_mode & ~ctrl_r.irq_flag));
  wire        fire_rst  = expire & (rst_mode | (comb_mode & ctrl_r.irq_flag));
  wire        any_reset = fire_rst | (|src_rise[SRC_USB:SRC_PIN]);

  // timed sequence
  wire        win_open  = (win_r == WIN_OPEN);
  wire        arm       = wr_ctrl & wr_c.chg_en & wr_c.rst_en;
  wire        win_load  = wr_ctrl & win_open & ~wr_c.chg_en;
  wire        irq_clr   = (wr_ctrl & wr_c.irq_flag) | irq_vector_ack;

  wire wdr_ctrl_t  ctrl_rd  = '{irq_flag: ctrl_r.irq_flag, irq_en: timeout_irq_enable_eff, pre_hi: ctrl_r.pre_hi,
                                chg_en: ctrl_r.chg_en, rst_en: wde_eff, pre_lo: ctrl_r.pre_lo};
  wire wdr_flags_t flags_rd = wdr_flags_t'(flags_r & FLAGS_USED_MASK);
  wire [DATA_W-1:0] rd_mux  = sel_flags ? {24'h00_0000, flags_rd} :
                              sel_ctrl  ? {24'h00_0000, ctrl_rd}  : 32'h0000_0000;

  always_comb begin
    win_nxt    = win_r;
    ce_cnt_nxt = ce_cnt_r;
    case (win_r)
      WIN_CLOSED: begin
        if (arm) begin
          win_nxt    = WIN_OPEN;
          ce_cnt_nxt = 3'(CE_HOLD_CYCLES - 1);
        end
      end
      WIN_OPEN: begin
        if (win_load || ce_cnt_r == 3'h0) begin
          win_nxt    = WIN_CLOSED;
          ce_cnt_nxt = 3'h0;
        end else begin
          ce_cnt_nxt = ce_cnt_r - 3'h1;
        end
      end
      default: begin
        win_nxt    = WIN_CLOSED;
        ce_cnt_nxt = 3'h0;
      end
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    // hardware set wins over a software clear in the same cycle
    ctrl_nxt.irq_flag = fire_irq | (ctrl_r.irq_flag & ~irq_clr);
    if (aon) begin
      ctrl_nxt.irq_en = 1'b0;
    end else if (wr_ctrl) begin
      ctrl_nxt.irq_en = wr_c.irq_en;
    end else if (irq_vector_ack && comb_mode) begin
      ctrl_nxt.irq_en = 1'b0;
    end
    // an ordinary write may only set the reset enable; clearing needs the window
    if (win_load) begin
      ctrl_nxt.rst_en = wr_c.rst_en;
      ctrl_nxt.pre_hi = wr_c.pre_hi;
      ctrl_nxt.pre_lo = wr_c.pre_lo;
    end else if (wr_ctrl) begin
      ctrl_nxt.rst_en = ctrl_r.rst_en | wr_c.rst_en;
    end
    ctrl_nxt.chg_en = (win_nxt == WIN_OPEN);
  end

  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = wdr_flags_t'(flags_r & wr_f);
    end
    flags_nxt.pin      = flags_nxt.pin      | src_rise[SRC_PIN];
    flags_nxt.supply   = flags_nxt.supply   | src_rise[SRC_SUPPLY];
    flags_nxt.timeout  = flags_nxt.timeout  | fire_rst;
    flags_nxt.scan     = flags_nxt.scan     | src_rise[SRC_SCAN];
    flags_nxt.usb      = flags_nxt.usb      | src_rise[SRC_USB];
    flags_nxt.rsvd     = 2'b00;
  end

  always_comb begin
    if (restart_cmd || !running || expire || any_reset) begin
      cnt_nxt = '0;
    end else if (osc_tick_r) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // power-up sets only the power-up flag; the other causes start cleared
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r  <= wdr_flags_t'(FLAGS_RST);
      ctrl_r   <= wdr_ctrl_t'(CTRL_RST);
      win_r    <= WIN_CLOSED;
      ce_cnt_r <= 3'h0;
      cnt_r    <= '0;
    end else begin
      flags_r  <= flags_nxt;
      ctrl_r   <= ctrl_nxt;
      win_r    <= win_nxt;
      ce_cnt_r <= ce_cnt_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // slow oscillator stand-in: one tick every OSC_DIV cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r      <= '0;
      osc_tick_r <= 1'b0;
    end else begin
      osc_tick_r <= (div_r == DIV_W'(OSC_DIV - 1));
      div_r      <= (div_r == DIV_W'(OSC_DIV - 1)) ? '0 : div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r   <= 1'b1;
      rdata_r  <= '0;
      irq_r    <= 1'b0;
      sysrst_r <= 1'b0;
    end else begin
      wait_r   <= ~(req & wait_r);
      if (avs_read && wait_r) begin
        rdata_r <= rd_mux;
      end
      // level output, independent of sleep, so it can wake the core
      irq_r    <= ctrl_nxt.irq_flag & ~aon;
      sysrst_r <= fire_rst;
    end
  end

  assign avs_readdata      = rdata_r;
  assign avs_waitrequest   = wait_r;
  assign timeout_irq       = irq_r;
  assign timeout_sys_reset = sysrst_r;

  // checks
  property p_rsvd_zero;
    avs_read && !avs_waitrequest && sel_flags |-> avs_readdata[7:6] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved flag bits read nonzero");

  property p_scan_flag;
    $rose(filt_r[SRC_SCAN]) |-> flags_r.scan;
  endproperty
  a_scan_flag: assert property (p_scan_flag) else $error("scan reset not recorded");

  property p_timeout_flag;
    timeout_sys_reset |-> flags_r.timeout && wde_eff;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("timeout reset not recorded");

  property p_supply_flag;
    $rose(filt_r[SRC_SUPPLY]) |-> flags_r.supply;
  endproperty
  a_supply_flag: assert property (p_supply_flag) else $error("supply drop not recorded");

  property p_pin_flag;
    $rose(filt_r[SRC_PIN]) |-> flags_r.pin;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin reset not recorded");

  property p_flag_clear;
    wr_flags && !wr_f.timeout && !fire_rst |=> !flags_r.timeout;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write zero did not clear flag");

  property p_power_up_kept;
    flags_r.power_up && !(wr_flags && !wr_f.power_up) |=> flags_r.power_up;
  endproperty
  a_power_up_kept: assert property (p_power_up_kept) else $error("power-up flag lost");

  property p_tick_count;
    cnt_r != '0 && $changed(cnt_r) |-> $past(osc_tick_r);
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("counter moved without a tick");

  property p_irq_mode;
    expire && intr_mode |=> ctrl_r.irq_flag && timeout_irq;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("interrupt mode expiry lost");

  property p_rst_mode;
    expire && rst_mode |=> timeout_sys_reset ##1 !timeout_sys_reset;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("reset mode expiry not a one-cycle pulse");

  property p_comb_first;
    expire && comb_mode && !ctrl_r.irq_flag |=> ctrl_r.irq_flag && !timeout_sys_reset;
  endproperty
  a_comb_first: assert property (p_comb_first) else $error("combined mode first expiry wrong");

  property p_period_bound;
    cnt_r <= tick_last(pre_code) || $changed(pre_code) || $past(restart_cmd);
  endproperty
  a_period_bound: assert property (p_period_bound) else $error("counter beyond selected period");

  property p_aon_lock;
    aon |-> wde_eff && !timeout_irq_enable_eff;
  endproperty
  a_aon_lock: assert property (p_aon_lock) else $error("always-on option not forcing reset mode");

  property p_pre_protected;
    $changed(pre_code) |-> $past(win_load);
  endproperty
  a_pre_protected: assert property (p_pre_protected) else $error("prescale changed outside window");

  property p_load_window;
    win_load |=> {ctrl_r.pre_hi, ctrl_r.pre_lo} == $past({wr_c.pre_hi, wr_c.pre_lo}) && !ctrl_r.chg_en;
  endproperty
  a_load_window: assert property (p_load_window) else $error("window write not loaded");

  property p_timeout_reset_flag_forces;
    flags_r.timeout |-> wde_eff;
  endproperty
  a_timeout_reset_flag_forces: assert property (p_timeout_reset_flag_forces) else $error("timeout flag not forcing reset enable");

  property p_ce_self_clear;
    $rose(ctrl_r.chg_en) |-> ##[1:4] !ctrl_r.chg_en;
  endproperty
  a_ce_self_clear: assert property (p_ce_self_clear) else $error("change enable held too long");

  property p_vector_ack;
    irq_vector_ack && comb_mode && !wr_ctrl && !fire_irq |=> !ctrl_r.irq_flag && !ctrl_r.irq_en;
  endproperty
  a_vector_ack: assert property (p_vector_ack) else $error("vector service did not leave combined mode");

  property p_restart;
    restart_cmd |=> cnt_r == '0 && $stable(ctrl_r.pre_lo);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear the counter");

endmodule : wdr_core

// *** core/wdr_pkg.sv ***
// Purpose: shared constants and types for the supervision timer with reset-cause flags
// Assumes: one 25 MHz clock; the slow oscillator is modelled as an enable pulse from a divider
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
//
// How it works
// - flag bits 7 and 6 always read zero
// - scan-port reset sets flag bit 4
// - timeout reset sets flag bit 3
// - supply-drop reset sets flag bit 2
// - reset pin sets flag bit 1
// - power-up clears other flags; write-zero clears
// - power-up flag set at power-up, write-zero clears
// - counter advances on 128 kHz oscillator ticks
// - unrestarted counter expiry triggers configured action
// - interrupt mode: expiry raises wake-capable interrupt
// - reset mode: expiry issues system reset
// - combined mode: interrupt first, then reset
// - period selectable from 16 ms to 8 s
// - always-on option forces reset-only mode, locked
// - clearing reset enable, prescale need timed sequence
// - second write within four cycles loads settings
// - enabled timer survives the reset it causes
// - timeout flag forces reset enable to one
// - change enable self-clears after four cycles
// - vector service clears flag; in combined mode also irq enable
package wdr_pkg;

  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;
  localparam logic [3:0]  OFS_FLAGS       = 4'h0;
  localparam logic [3:0]  OFS_CTRL        = 4'h4;

  localparam logic [7:0]  FLAGS_RST       = 8'h01;
  localparam logic [7:0]  FLAGS_USED_MASK = 8'h3F;
  localparam logic [7:0]  CTRL_RST        = 8'h00;

  // external reset sources and the fuse, index into the synchroniser vector
  localparam int unsigned SRC_PIN         = 0;
  localparam int unsigned SRC_SUPPLY      = 1;
  localparam int unsigned SRC_SCAN        = 2;
  localparam int unsigned SRC_USB         = 3;
  localparam int unsigned SRC_AON         = 4;
  localparam int unsigned SRC_N           = 5;

  localparam int unsigned CLK_FREQ_KHZ    = 25000;
  localparam int unsigned OSC_FREQ_KHZ    = 128;
  localparam int unsigned OSC_DIV_CYCLES  = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
  localparam int unsigned CE_HOLD_CYCLES  = 4;
  localparam int unsigned PRE_BASE_TICKS  = 2048;
  localparam logic [3:0]  PRE_MAX_CODE    = 4'h9;
  localparam int unsigned CNT_W           = 21;

  typedef struct packed {
    logic       irq_flag;
    logic       irq_en;
    logic       pre_hi;
    logic       chg_en;
    logic       rst_en;
    logic [2:0] pre_lo;
  } wdr_ctrl_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       usb;
    logic       scan;
    logic       timeout;
    logic       supply;
    logic       pin;
    logic       power_up;
  } wdr_flags_t;

  typedef enum logic [1:0] {
    WIN_CLOSED = 2'b01,
    WIN_OPEN   = 2'b10
  } wdr_win_t;

endpackage : wdr_pkg

// *** tb/wdr_src_model.sv ***
// Purpose: on-chip reset sources seen by the timer; each fire request becomes an event level
// Assumes: ref_clk domain; fire is a one-cycle request per source
// Notes:   the level is held four cycles so that the three-stage input synchroniser sees it
`timescale 1ns/10ps

module wdr_src_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] fire,
  output logic      [3:0] evt
);
  logic [2:0] hold_r [4];

  for (genvar i = 0; i < 4; i++) begin : g_src
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        hold_r[i] <= 3'h0;
      end else if (fire[i]) begin
        hold_r[i] <= 3'h4;
      end else if (hold_r[i] != 3'h0) begin
        hold_r[i] <= hold_r[i] - 3'h1;
      end
    end
    assign evt[i] = (hold_r[i] != 3'h0);
  end
endmodule : wdr_src_model

// *** tb/wdr_core_tb.sv ***
// Purpose: self-checking bench for the supervision timer and reset-cause flags
// Assumes: short counts (OSC_DIV 2, BASE_TICKS 4) so that every period is reachable
// Notes:   expiry times are checked from one oscillator tick early to three cycles late
`timescale 1ns/10ps

module wdr_core_tb;
  import wdr_pkg::*;
  localparam int unsigned DIV  = 2;
  localparam int unsigned BASE = 4;
  logic              ref_clk;
  logic              reset_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              restart_cmd;
  logic              irq_vector_ack;
  logic              always_on_option;
  logic [3:0]        fire;
  logic [3:0]        evt;
  logic              timeout_irq;
  logic              timeout_sys_reset;
  logic [7:0]        q;
  logic [7:0]        exp_flags;
  logic [31:0]       rnd;
  int                err_count = 0;
  int                n_checks = 0;
  int                pulses = 0;
  int                p0;
  int                n;
  int                codes [5] = '{0, 1, 2, 9, 12};

  wdr_core #(.OSC_DIV(DIV), .BASE_TICKS(BASE)) u_wdr_core (
    .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .restart_cmd(restart_cmd),
    .irq_vector_ack(irq_vector_ack), .always_on_option(always_on_option), .pin_reset_evt(evt[0]),
    .supply_drop_evt(evt[1]), .scan_reset_evt(evt[2]), .usb_reset_evt(evt[3]),
    .timeout_irq(timeout_irq), .timeout_sys_reset(timeout_sys_reset));
  wdr_src_model u_wdr_src_model (.ref_clk(ref_clk), .reset_n(reset_n), .fire(fire), .evt(evt));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (timeout_sys_reset === 1'b1) pulses++;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // reserved codes run the longest period
  function automatic int per(input int c);
    return (BASE << ((c > int'(PRE_MAX_CODE)) ? int'(PRE_MAX_CODE) : c)) * DIV;
  endfunction : per

  function automatic logic [7:0] code_bits(input int c);
    return {2'b00, c[3], 2'b00, c[2:0]};
  endfunction : code_bits

  function automatic logic [7:0] src_mask(input int i);
    case (i)
      0: return 8'h02;
      1: return 8'h04;
      2: return 8'h10;
      default: return 8'h20;
    endcase
  endfunction : src_mask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // keep holds the strobe so a following write lands two cycles after this one
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input bit keep = 1'b0);
    int k;
    k = 0;
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    chk(32'(k), 32'h2);
    if (!keep) begin
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk({24'h00_0000, q}, {24'h00_0000, exp});
  endtask : rd

  task automatic tseq(input logic [7:0] d);
    bus(1'b1, OFS_CTRL, 8'h18 | (d & 8'h27), 1'b1);
    bus(1'b1, OFS_CTRL, d);
  endtask : tseq

  task automatic pulse_restart();
    restart_cmd <= 1'b1;
    @(posedge ref_clk);
    restart_cmd <= 1'b0;
  endtask : pulse_restart

  task automatic pulse_ack();
    irq_vector_ack <= 1'b1;
    @(posedge ref_clk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse_ack

  task automatic wait_out(input bit rst, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
    end while ((rst ? timeout_sys_reset : timeout_irq) !== 1'b1 && cnt < lim);
  endtask : wait_out

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    restart_cmd = 1'b0;
    irq_vector_ack = 1'b0;
    always_on_option = 1'b0;
    fire = 4'h0;
    rnd = 32'h0000_98ef;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_FLAGS, 8'h01);
    rnd = lfsr_next(rnd);
    rd({1'b1, rnd[2:0]}, 8'h00);
    bus(1'b1, {1'b1, rnd[2:0]}, 8'hff);
    rd(OFS_CTRL, 8'h00);
    bus(1'b1, OFS_FLAGS, 8'hff);
    rd(OFS_FLAGS, 8'h01);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_FLAGS, 8'h00);
    avs_byteenable <= 4'hf;
    rd(OFS_FLAGS, 8'h01);
    bus(1'b1, OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00);
    exp_flags = 8'h00;
    for (int i = 0; i < 4; i++) begin
      fire <= 4'h1 << i;
      @(posedge ref_clk);
      fire <= 4'h0;
      repeat (8) @(posedge ref_clk);
      exp_flags = exp_flags | src_mask(i);
      rd(OFS_FLAGS, exp_flags);
    end
    rnd = lfsr_next(rnd);
    bus(1'b1, OFS_FLAGS, rnd[7:0]);
    rd(OFS_FLAGS, exp_flags & rnd[7:0]);
    bus(1'b1, OFS_FLAGS, 8'h00);
    foreach (codes[k]) begin
      pulse_restart();
      tseq(code_bits(codes[k]) | 8'h40);
      pulse_restart();
      wait_out(1'b0, 5000, n);
      chk(32'(n >= per(codes[k]) - DIV && n <= per(codes[k]) + 3), 32'h1);
      pulse_ack();
      pulse_restart();
      chk({31'h0, timeout_irq}, 32'h0);
      rd(OFS_CTRL, code_bits(codes[k]) | 8'h40);
    end
    chk(32'(pulses), 32'h0);
    pulse_restart();
    tseq(8'h40);
    for (int j = 0; j < 20; j++) begin
      pulse_restart();
      rnd = lfsr_next(rnd);
      repeat (rnd[1:0]) @(posedge ref_clk);
      chk({31'h0, timeout_irq}, 32'h0);
    end
    rd(OFS_CTRL, 8'h40);
    wait_out(1'b0, 100, n);
    chk(32'(n <= per(0) + 3), 32'h1);
    pulse_ack();
    pulse_restart();
    tseq(8'h0b);
    bus(1'b1, OFS_CTRL, 8'h1b);
    rd(OFS_CTRL, 8'h1b);
    repeat (4) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h0b);
    bus(1'b1, OFS_CTRL, 8'h00);
    rd(OFS_CTRL, 8'h0b);
    bus(1'b1, OFS_CTRL, 8'h0d);
    rd(OFS_CTRL, 8'h0b);
    wait_out(1'b1, 200, n);
    chk(32'(n < 200), 32'h1);
    rd(OFS_FLAGS, 8'h08);
    rd(OFS_CTRL, 8'h0b);
    wait_out(1'b1, 200, n);
    chk(32'(n < 200), 32'h1);
    pulse_restart();
    tseq(8'h03);
    rd(OFS_CTRL, 8'h0b);
    pulse_restart();
    bus(1'b1, OFS_FLAGS, 8'h00);
    tseq(8'h00);
    rd(OFS_CTRL, 8'h00);
    pulse_restart();
    p0 = pulses;
    bus(1'b1, OFS_CTRL, 8'h48);
    wait_out(1'b0, 200, n);
    chk(32'(pulses - p0), 32'h0);
    rd(OFS_CTRL, 8'hc8);
    wait_out(1'b1, 200, n);
    chk(32'(n < 200), 32'h1);
    pulse_restart();
    bus(1'b1, OFS_CTRL, 8'hc8);
    wait_out(1'b0, 200, n);
    chk(32'(n > 2), 32'h1);
    pulse_ack();
    chk({31'h0, timeout_irq}, 32'h0);
    rd(OFS_CTRL, 8'h08);
    pulse_restart();
    bus(1'b1, OFS_FLAGS, 8'h00);
    tseq(8'h00);
    always_on_option <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(OFS_CTRL, 8'h08);
    bus(1'b1, OFS_CTRL, 8'h40);
    tseq(8'h00);
    rd(OFS_CTRL, 8'h08);
    wait_out(1'b1, 200, n);
    chk(32'(n < 200), 32'h1);
    fire <= 4'h1;
    @(posedge ref_clk);
    fire <= 4'h0;
    repeat (8) @(posedge ref_clk);
    rd(OFS_FLAGS, 8'h0a);
    reset_n <= 1'b0;
    always_on_option <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_FLAGS, 8'h01);
    rd(OFS_CTRL, 8'h00);
    stop_test();
  end
endmodule : wdr_core_tb
